//--- rtl/gpio_abc.sv
// general purpose io logic for ports a, b and c
`timescale 1ns/1ps
module gpio_abc (
	input  wire logic                        MCLK,
	input  wire logic                        ARST_N,
	input  wire logic [gpio_abc_pkg::ADDR_W-1:0] ADDR,
	input  wire logic [7:0]                  WDATA,
	input  wire logic                        WR,
	input  wire logic                        RD,
	output logic      [7:0]                  RDATA,
	input  wire gpio_abc_pkg::periph_s       PERIPH,
	output logic      [1:0]                  TIMER_IN,
	input  wire logic [gpio_abc_pkg::A_W-1:0] PA_I,
	output logic      [gpio_abc_pkg::A_W-1:0] PA_O,
	output logic      [gpio_abc_pkg::A_W-1:0] PA_OE,
	input  wire logic [gpio_abc_pkg::B_W-1:0] PB_I,
	output logic      [gpio_abc_pkg::B_W-1:0] PB_O,
	output logic      [gpio_abc_pkg::B_W-1:0] PB_OE,
	output logic      [gpio_abc_pkg::B_W-1:0] CONV_SEL,
	input  wire logic [gpio_abc_pkg::C_W-1:0] PC_I,
	output logic      [gpio_abc_pkg::C_W-1:0] PC_O,
	output logic      [gpio_abc_pkg::C_W-1:0] PC_OE
);
	import gpio_abc_pkg::*;

	logic [A_W-1:0] a_lat_q, a_dir_q, a_s1_q, a_s2_q;
	logic [B_W-1:0] b_lat_q, b_dir_q, b_s1_q, b_s2_q;
	logic [C_W-1:0] c_lat_q, c_dir_q, c_s1_q, c_s2_q;
	logic           clk_en_q;
	logic [B_W-1:0] conv_pin;
	logic [B_W-1:0] b_read;
	logic [7:0]     rdata_d;

	// data latches have no reset
	always_ff @(posedge MCLK) begin
		if (WR && ADDR == PORT_A_DATA_OFS) begin
			a_lat_q <= WDATA[A_W-1:0];
		end
		if (WR && ADDR == PORT_B_DATA_OFS) begin
			b_lat_q <= WDATA;
		end
		if (WR && ADDR == PORT_C_DATA_OFS) begin
			c_lat_q <= WDATA[C_W-1:0];
		end
	end

	always_ff @(posedge MCLK or negedge ARST_N) begin
		if (!ARST_N) begin
			a_dir_q  <= A_DIR_RST;
			b_dir_q  <= B_DIR_RST;
			c_dir_q  <= C_DIR_RST;
			clk_en_q <= 1'b0;
		end else if (WR) begin
			if (ADDR == PORT_A_DIR_OFS) begin
				a_dir_q <= WDATA[A_W-1:0];
			end
			if (ADDR == PORT_B_DIR_OFS) begin
				b_dir_q <= WDATA;
			end
			if (ADDR == PORT_C_DIR_OFS) begin
				c_dir_q  <= WDATA[C_W-1:0];
				clk_en_q <= WDATA[CLK_OUT_EN_BIT];
			end
		end
	end

	// two-stage pin synchronisers
	always_ff @(posedge MCLK or negedge ARST_N) begin
		if (!ARST_N) begin
			a_s1_q <= '0;
			a_s2_q <= '0;
			b_s1_q <= '0;
			b_s2_q <= '0;
			c_s1_q <= '0;
			c_s2_q <= '0;
		end else begin
			a_s1_q <= PA_I;
			a_s2_q <= a_s1_q;
			b_s1_q <= PB_I;
			b_s2_q <= b_s1_q;
			c_s1_q <= PC_I;
			c_s2_q <= c_s1_q;
		end
	end

	// converter channel decode
	genvar gi;
	generate
		for (gi = 0; gi < B_W; gi++) begin : g_conv
			assign conv_pin[gi] = PERIPH.conv_active && PERIPH.chan_sel <= CHAN_LAST_PIN
				&& PERIPH.chan_sel[2:0] == 3'(gi);
		end
	endgenerate
	assign CONV_SEL = conv_pin;

	// port pin drivers
	always_comb begin
		PA_O  = a_lat_q;
		PA_OE = a_dir_q;
		PB_O  = b_lat_q;
		PB_OE = b_dir_q & ~conv_pin;
		for (int i = TIMER_PIN_LO; i < B_W; i++) begin
			if (!conv_pin[i] && PERIPH.timer_own[i-TIMER_PIN_LO]) begin
				PB_O[i]  = PERIPH.timer_out[i-TIMER_PIN_LO];
				PB_OE[i] = PERIPH.timer_oe[i-TIMER_PIN_LO];
			end
		end
		PC_O  = c_lat_q;
		PC_OE = c_dir_q;
		if (clk_en_q) begin
			PC_O[CLK_OUT_PIN]  = MCLK;
			PC_OE[CLK_OUT_PIN] = 1'b1;
		end
	end

	// timer capture input, cut off while converter owns the pin
	always_ff @(posedge MCLK or negedge ARST_N) begin
		if (!ARST_N) begin
			TIMER_IN <= 2'h0;
		end else begin
			for (int i = 0; i < 2; i++) begin
				TIMER_IN[i] <= b_s2_q[TIMER_PIN_LO+i] & ~conv_pin[TIMER_PIN_LO+i];
			end
		end
	end

	// read path
	always_comb begin
		for (int i = 0; i < B_W; i++) begin
			if (conv_pin[i]) begin
				b_read[i] = b_dir_q[i] & b_lat_q[i];
			end else begin
				b_read[i] = b_dir_q[i] ? b_lat_q[i] : b_s2_q[i];
			end
		end
		case (ADDR)
			PORT_A_DATA_OFS: rdata_d = {1'b0, (a_dir_q & a_lat_q) | (~a_dir_q & a_s2_q)};
			PORT_B_DATA_OFS: rdata_d = b_read;
			PORT_C_DATA_OFS: rdata_d = {3'h0, (c_dir_q & c_lat_q) | (~c_dir_q & c_s2_q)};
			PORT_A_DIR_OFS:  rdata_d = {1'b0, a_dir_q};
			PORT_B_DIR_OFS:  rdata_d = b_dir_q;
			PORT_C_DIR_OFS:  rdata_d = {clk_en_q, 2'h0, c_dir_q};
			default:         rdata_d = 8'h00;
		endcase
	end

	always_ff @(posedge MCLK or negedge ARST_N) begin
		if (!ARST_N) begin
			RDATA <= 8'h00;
		end else if (RD) begin
			RDATA <= rdata_d;
		end else begin
			RDATA <= 8'h00;
		end
	end

	dir_reset_a: assert property (@(posedge MCLK) $rose(ARST_N) |-> a_dir_q == '0 && b_dir_q == '0)
		else $error("direction not cleared by reset");
	clk_out_a: assert property (@(posedge MCLK) disable iff (!ARST_N)
		clk_en_q |-> PC_OE[CLK_OUT_PIN])
		else $error("clock out pin not driven");
	conv_drive_a: assert property (@(posedge MCLK) disable iff (!ARST_N)
		|conv_pin |-> (PB_OE & conv_pin) == '0)
		else $error("converter pin driven");
	dir_drive_a: assert property (@(posedge MCLK) disable iff (!ARST_N) PA_OE == a_dir_q)
		else $error("port a enable mismatch");
	latch_write_a: assert property (@(posedge MCLK) disable iff (!ARST_N)
		WR && ADDR == PORT_B_DATA_OFS |=> b_lat_q == $past(WDATA))
		else $error("latch not written");
	read_a_out_a: assert property (@(posedge MCLK) disable iff (!ARST_N)
		RD && ADDR == PORT_A_DIR_OFS |=> RDATA == {1'b0, $past(a_dir_q)})
		else $error("direction readback wrong");
	conv_read_a: assert property (@(posedge MCLK) disable iff (!ARST_N)
		RD && ADDR == PORT_B_DATA_OFS && conv_pin[0] && !b_dir_q[0] |=> RDATA[0] == 1'b0)
		else $error("converter input bit not zero");
	read_c_dir_a: assert property (@(posedge MCLK) disable iff (!ARST_N)
		WR && ADDR == PORT_C_DIR_OFS ##1 RD && ADDR == PORT_C_DIR_OFS
		|=> RDATA[CLK_OUT_EN_BIT] == $past(WDATA[CLK_OUT_EN_BIT], 2))
		else $error("clock out enable readback wrong");
	timer_cut_a: assert property (@(posedge MCLK) disable iff (!ARST_N)
		conv_pin[TIMER_PIN_LO] |=> TIMER_IN[0] == 1'b0)
		else $error("timer sees converter pin");

	a_lat_write_a: assert property (@(posedge MCLK) disable iff (!ARST_N)
		WR && ADDR == PORT_A_DATA_OFS
		|=> a_lat_q == $past(WDATA[A_W-1:0]))
		else $error("port a latch not written");

	c_lat_write_a: assert property (@(posedge MCLK) disable iff (!ARST_N)
		WR && ADDR == PORT_C_DATA_OFS
		|=> c_lat_q == $past(WDATA[C_W-1:0]))
		else $error("port c latch not written");

	a_dir_write_a: assert property (@(posedge MCLK) disable iff (!ARST_N)
		WR && ADDR == PORT_A_DIR_OFS
		|=> a_dir_q == $past(WDATA[A_W-1:0]))
		else $error("port a direction not written");

	b_dir_write_a: assert property (@(posedge MCLK) disable iff (!ARST_N)
		WR && ADDR == PORT_B_DIR_OFS
		|=> b_dir_q == $past(WDATA))
		else $error("port b direction not written");

	c_dir_write_a: assert property (@(posedge MCLK) disable iff (!ARST_N)
		WR && ADDR == PORT_C_DIR_OFS
		|=> c_dir_q == $past(WDATA[C_W-1:0]))
		else $error("port c direction not written");

	clk_en_write_a: assert property (@(posedge MCLK) disable iff (!ARST_N)
		WR && ADDR == PORT_C_DIR_OFS
		|=> clk_en_q == $past(WDATA[CLK_OUT_EN_BIT]))
		else $error("clock out enable not written");

	a_dir_hold_a: assert property (@(posedge MCLK) disable iff (!ARST_N)
		!(WR && ADDR == PORT_A_DIR_OFS)
		|=> $stable(a_dir_q))
		else $error("port a direction changed unasked");

	b_dir_hold_a: assert property (@(posedge MCLK) disable iff (!ARST_N)
		!(WR && ADDR == PORT_B_DIR_OFS)
		|=> $stable(b_dir_q))
		else $error("port b direction changed unasked");

	c_dir_hold_a: assert property (@(posedge MCLK) disable iff (!ARST_N)
		!(WR && ADDR == PORT_C_DIR_OFS)
		|=> $stable(c_dir_q))
		else $error("port c direction changed unasked");

	clk_en_hold_a: assert property (@(posedge MCLK) disable iff (!ARST_N)
		!(WR && ADDR == PORT_C_DIR_OFS)
		|=> $stable(clk_en_q))
		else $error("clock out enable changed unasked");

	a_read_out_a: assert property (@(posedge MCLK) disable iff (!ARST_N)
		RD && ADDR == PORT_A_DATA_OFS
		|=> (RDATA[A_W-1:0] & $past(a_dir_q)) == ($past(a_lat_q) & $past(a_dir_q)))
		else $error("port a output bits not from latch");

	a_read_in_a: assert property (@(posedge MCLK) disable iff (!ARST_N)
		RD && ADDR == PORT_A_DATA_OFS
		|=> (RDATA[A_W-1:0] & ~$past(a_dir_q)) == ($past(a_s2_q) & ~$past(a_dir_q)))
		else $error("port a input bits not from pins");

	a_read_top_a: assert property (@(posedge MCLK) disable iff (!ARST_N)
		RD && ADDR == PORT_A_DATA_OFS
		|=> RDATA[7] == 1'b0)
		else $error("port a unused bit not zero");

	c_read_out_a: assert property (@(posedge MCLK) disable iff (!ARST_N)
		RD && ADDR == PORT_C_DATA_OFS
		|=> (RDATA[C_W-1:0] & $past(c_dir_q)) == ($past(c_lat_q) & $past(c_dir_q)))
		else $error("port c output bits not from latch");

	c_read_in_a: assert property (@(posedge MCLK) disable iff (!ARST_N)
		RD && ADDR == PORT_C_DATA_OFS
		|=> (RDATA[C_W-1:0] & ~$past(c_dir_q)) == ($past(c_s2_q) & ~$past(c_dir_q)))
		else $error("port c input bits not from pins");

	c_read_top_a: assert property (@(posedge MCLK) disable iff (!ARST_N)
		RD && ADDR == PORT_C_DATA_OFS
		|=> RDATA[7:C_W] == 3'h0)
		else $error("port c unused bits not zero");

	b_dir_read_a: assert property (@(posedge MCLK) disable iff (!ARST_N)
		RD && ADDR == PORT_B_DIR_OFS
		|=> RDATA == $past(b_dir_q))
		else $error("port b direction readback wrong");

	c_dir_read_a: assert property (@(posedge MCLK) disable iff (!ARST_N)
		RD && ADDR == PORT_C_DIR_OFS
		|=> RDATA == {$past(clk_en_q), 2'h0, $past(c_dir_q)})
		else $error("port c direction readback wrong");

	idle_read_a: assert property (@(posedge MCLK) disable iff (!ARST_N)
		!RD
		|=> RDATA == 8'h00)
		else $error("read data outside read cycle");

	unmapped_read_a: assert property (@(posedge MCLK) disable iff (!ARST_N)
		RD && (ADDR == 4'h3 || ADDR > PORT_C_DIR_OFS)
		|=> RDATA == 8'h00)
		else $error("unmapped address not zero");

	c_dir_reset_a: assert property (@(posedge MCLK)
		$rose(ARST_N)
		|-> c_dir_q == '0 && !clk_en_q)
		else $error("port c direction not cleared by reset");

	out_reset_a: assert property (@(posedge MCLK)
		$rose(ARST_N)
		|-> RDATA == 8'h00 && TIMER_IN == 2'h0)
		else $error("outputs not cleared by reset");

	pc_drive_a: assert property (@(posedge MCLK) disable iff (!ARST_N)
		!clk_en_q
		|-> PC_OE == c_dir_q)
		else $error("port c enable mismatch");

	pa_data_a: assert property (@(posedge MCLK) disable iff (!ARST_N)
		1'b1
		|-> (PA_O & a_dir_q) == (a_lat_q & a_dir_q))
		else $error("port a drives wrong level");

	pc_data_a: assert property (@(posedge MCLK) disable iff (!ARST_N)
		!clk_en_q
		|-> (PC_O & c_dir_q) == (c_lat_q & c_dir_q))
		else $error("port c drives wrong level");

	pb_data_a: assert property (@(posedge MCLK) disable iff (!ARST_N)
		1'b1
		|-> (PB_O & b_dir_q & ~conv_pin & ~{PERIPH.timer_own, 6'h00})
			== (b_lat_q & b_dir_q & ~conv_pin & ~{PERIPH.timer_own, 6'h00}))
		else $error("port b drives wrong level");

	conv_onehot_a: assert property (@(posedge MCLK) disable iff (!ARST_N)
		1'b1
		|-> $onehot0(CONV_SEL))
		else $error("more than one converter pin");

	conv_code_a: assert property (@(posedge MCLK) disable iff (!ARST_N)
		PERIPH.conv_active && PERIPH.chan_sel <= CHAN_LAST_PIN
		|-> CONV_SEL[PERIPH.chan_sel[2:0]])
		else $error("selected converter pin not connected");

	conv_off_a: assert property (@(posedge MCLK) disable iff (!ARST_N)
		!PERIPH.conv_active
		|-> CONV_SEL == '0)
		else $error("converter pin without conversion");

	timer_in_a: assert property (@(posedge MCLK) disable iff (!ARST_N)
		!conv_pin[TIMER_PIN_LO+1]
		|=> TIMER_IN[1] == $past(b_s2_q[TIMER_PIN_LO+1]))
		else $error("timer input not from pin");

	// timer pin ownership per channel
	genvar gt;
	generate
		for (gt = 0; gt < 2; gt++) begin : g_timer_chk
			timer_drive_a: assert property (@(posedge MCLK) disable iff (!ARST_N)
				!conv_pin[TIMER_PIN_LO+gt] && PERIPH.timer_own[gt]
				|-> PB_OE[TIMER_PIN_LO+gt] == PERIPH.timer_oe[gt]
					&& PB_O[TIMER_PIN_LO+gt] == PERIPH.timer_out[gt])
				else $error("timer pin not driven by timer");
			timer_gpio_a: assert property (@(posedge MCLK) disable iff (!ARST_N)
				!conv_pin[TIMER_PIN_LO+gt] && !PERIPH.timer_own[gt]
				|-> PB_OE[TIMER_PIN_LO+gt] == b_dir_q[TIMER_PIN_LO+gt])
				else $error("released timer pin not general purpose");
		end
	endgenerate

	// lower port b pins follow direction unless converted
	genvar gl;
	generate
		for (gl = 0; gl < TIMER_PIN_LO; gl++) begin : g_low_chk
			gpio_oe_a: assert property (@(posedge MCLK) disable iff (!ARST_N)
				!conv_pin[gl]
				|-> PB_OE[gl] == b_dir_q[gl])
				else $error("port b enable mismatch");
		end
	endgenerate

	// port b read per bit
	genvar gb;
	generate
		for (gb = 0; gb < B_W; gb++) begin : g_bread_chk
			b_conv_read_a: assert property (@(posedge MCLK) disable iff (!ARST_N)
				RD && ADDR == PORT_B_DATA_OFS && conv_pin[gb]
				|=> RDATA[gb] == $past(b_dir_q[gb] & b_lat_q[gb]))
				else $error("converter pin read wrong");
			b_out_read_a: assert property (@(posedge MCLK) disable iff (!ARST_N)
				RD && ADDR == PORT_B_DATA_OFS && !conv_pin[gb] && b_dir_q[gb]
				|=> RDATA[gb] == $past(b_lat_q[gb]))
				else $error("port b output bit not from latch");
			b_in_read_a: assert property (@(posedge MCLK) disable iff (!ARST_N)
				RD && ADDR == PORT_B_DATA_OFS && !conv_pin[gb] && !b_dir_q[gb]
				|=> RDATA[gb] == $past(b_s2_q[gb]))
				else $error("port b input bit not from pin");
		end
	endgenerate
endmodule : gpio_abc

//--- shared/gpio_abc_pkg.sv
// shared constants and types for the three-port general purpose io block
// Behaviour
// - port a: seven pins, latches kept through reset
// - direction one drives pin, zero is input
// - reset clears all port a directions
// - port a read: latch if output, pin if input
// - data writes always update latches
// - port b: eight pins, latches kept through reset
// - reset clears all port b directions
// - port b read: latch if output, pin if input
// - converter wins over timer on upper pins
// - channel select picks converter or gpio per pin
// - converter pin reads zero when input
// - converter pin ignores direction for driver
// - edge/level select gives upper pins to timer
// - port c: five pins, latches kept through reset
// - clock-out enable drives system clock on pin two
// - clock-out enable readable, overrides pin two
// - reset clears port c directions and clock-out
// - channel codes zero to seven pick port b pins
package gpio_abc_pkg;
	localparam int unsigned ADDR_W = 4;
	localparam int unsigned A_W    = 7;
	localparam int unsigned B_W    = 8;
	localparam int unsigned C_W    = 5;
	localparam logic [ADDR_W-1:0] PORT_A_DATA_OFS = 4'h0;
	localparam logic [ADDR_W-1:0] PORT_B_DATA_OFS = 4'h1;
	localparam logic [ADDR_W-1:0] PORT_C_DATA_OFS = 4'h2;
	localparam logic [ADDR_W-1:0] PORT_A_DIR_OFS  = 4'h4;
	localparam logic [ADDR_W-1:0] PORT_B_DIR_OFS  = 4'h5;
	localparam logic [ADDR_W-1:0] PORT_C_DIR_OFS  = 4'h6;
	localparam int unsigned CLK_OUT_EN_BIT = 7;
	localparam int unsigned CLK_OUT_PIN    = 2;
	localparam int unsigned TIMER_PIN_LO   = 6;
	localparam logic [4:0]  CHAN_LAST_PIN  = 5'h07;
	localparam logic [A_W-1:0] A_DIR_RST   = 7'h00;
	localparam logic [B_W-1:0] B_DIR_RST   = 8'h00;
	localparam logic [C_W-1:0] C_DIR_RST   = 5'h00;
	typedef struct packed {
		logic [4:0] chan_sel;
		logic       conv_active;
		logic [1:0] timer_own;
		logic [1:0] timer_out;
		logic [1:0] timer_oe;
	} periph_s;
endpackage : gpio_abc_pkg

//--- verification/pin_world.sv
// far-side pad model: each pad shows the block's drive or the outside level
`timescale 1ns/1ps
module pin_world (
	input  wire logic [19:0] o,
	input  wire logic [19:0] oe,
	input  wire logic [19:0] ext,
	output logic      [19:0] pin
);
	assign pin = (oe & o) | (~oe & ext);
endmodule : pin_world

//--- verification/test_parallel_io_ports_abc.sv
// randomised bench for the three-port io block
`timescale 1ns/1ps
module test_parallel_io_ports_abc;
	import gpio_abc_pkg::*;
	logic          mclk = 0, arst_n = 0, wr = 0, rd = 0;
	logic [3:0]    addr = 0;
	logic [7:0]    wdata = 0, rdata, v, conv_sel;
	logic [7:0]    lat [3];
	logic [7:0]    dir [3] = '{8'h00, 8'h00, 8'h00};
	logic [1:0]    timer_in;
	logic [19:0]   o, oe, pin, ext = 0;
	periph_s       periph = '0;
	int            failures = 0, total_checks = 0, seed = 17953, k;
	gpio_abc dut (.MCLK(mclk), .ARST_N(arst_n), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd),
		.RDATA(rdata), .PERIPH(periph), .TIMER_IN(timer_in), .PA_I(pin[6:0]), .PA_O(o[6:0]),
		.PA_OE(oe[6:0]), .PB_I(pin[14:7]), .PB_O(o[14:7]), .PB_OE(oe[14:7]),
		.CONV_SEL(conv_sel), .PC_I(pin[19:15]), .PC_O(o[19:15]), .PC_OE(oe[19:15]));
	pin_world pads (.o(o), .oe(oe), .ext(ext), .pin(pin));
	always #4 mclk = ~mclk;
	task check(input logic [7:0] seen, input logic [7:0] exp);
		total_checks++;
		if (seen !== exp) begin
			failures++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	task wr_reg(input logic [3:0] a, input logic [7:0] d);
		@(posedge mclk) begin addr <= a; wdata <= d; wr <= 1; end
		@(posedge mclk) wr <= 0;
	endtask : wr_reg
	task rd_reg(input logic [3:0] a);
		@(posedge mclk) begin addr <= a; rd <= 1; end
		@(posedge mclk) rd <= 0;
		#1 v = rdata;
	endtask : rd_reg
	task stop_test;
		if (failures == 0 && total_checks > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask : stop_test
	function automatic logic [7:0] msk(int p);
		return (p == 0) ? 8'h7f : (p == 1) ? 8'hff : 8'h1f;
	endfunction : msk
	function automatic logic [7:0] sl(logic [19:0] x, int p);
		return (p == 0) ? {1'b0, x[6:0]} : (p == 1) ? x[14:7] : {3'h0, x[19:15]};
	endfunction : sl
	function automatic logic [7:0] exp_rd(int p);
		logic [7:0] pv;
		logic [2:0] c;
		pv = sl(ext, p);
		c = periph.chan_sel[2:0];
		exp_rd = ((dir[p] & lat[p]) | (~dir[p] & pv)) & msk(p);
		if (p == 1 && periph.conv_active) exp_rd[c] = dir[1][c] & lat[1][c];
	endfunction : exp_rd
	task put(int p);
		@(posedge mclk) ext <= $random(seed);
		lat[p] = 8'($random(seed));
		dir[p] = 8'($random(seed)) & msk(p);
		wr_reg(4'(p), lat[p]);
		wr_reg(4'(4 + p), dir[p]);
		repeat (3) @(posedge mclk);
		rd_reg(4'(p));
		check(v & msk(p), exp_rd(p));
	endtask : put
	initial begin
		repeat (16) @(posedge mclk);
		arst_n <= 1;
		for (k = 0; k < 3; k++) begin rd_reg(4'(4 + k)); check(v, 8'h00); end
		rd_reg(3); check(v, 8'h00);
		repeat (60) begin
			k = $unsigned($random(seed)) % 3;
			put(k);
			check(sl(oe, k), dir[k]);
			check(sl(o, k) & dir[k], lat[k] & dir[k]);
		end
		for (k = 0; k < 8; k++) begin
			@(posedge mclk) begin periph.chan_sel <= 5'(k); periph.conv_active <= 1; end
			put(1);
			check(conv_sel, 8'h01 << k);
			check({7'h0, oe[7 + k]}, 8'h00);
		end
		@(posedge mclk) periph <= '{5'h0, 1'b0, 2'b11, 2'b10, 2'b11};
		repeat (4) @(posedge mclk);
		check({6'h0, oe[14:13]}, 8'h03);
		check({6'h0, o[14:13]}, 8'h02);
		check({6'h0, timer_in}, 8'h02);
		@(posedge mclk) begin periph.chan_sel <= 5'h06; periph.conv_active <= 1; end
		repeat (4) @(posedge mclk);
		check({6'h0, oe[14:13]}, 8'h02);
		check({6'h0, timer_in}, 8'h02);
		@(posedge mclk) periph <= '0;
		wr_reg(6, 8'h80);
		rd_reg(6); check(v, 8'h80);
		@(posedge mclk) #1 check({o[17], oe[17]}, 8'h03);
		#4 check({o[17], oe[17]}, 8'h01);
		wr_reg(6, 8'h00);
		@(posedge mclk) arst_n <= 0;
		repeat (2) @(posedge mclk) arst_n <= 1;
		for (k = 0; k < 3; k++) begin
			rd_reg(4'(4 + k)); check(v, 8'h00);
			dir[k] = msk(k);
			wr_reg(4'(4 + k), dir[k]);
			rd_reg(4'(k)); check(v & msk(k), exp_rd(k));
		end
		stop_test();
	end
	initial begin
		repeat (20000) @(posedge mclk);
		failures++;
		stop_test();
	end
endmodule : test_parallel_io_ports_abc
